// *** rtl/cicp_config_port.sv ***
// Serial configuration port: bus slave, register file and non-volatile copy.
// Assumes open-drain bus pins resolved outside and power-stage flags from another clock.
`timescale 1ns/1ps
module cicp_config_port
   import cicp_pkg::*;
(
   // System
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   // Bus pins
   input  wire logic       scl,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOe,
   // Power-stage flags
   input  wire logic       thermalTripFlag,
   input  wire logic       hotDie,
   input  wire logic       pfmActive,
   input  wire logic       dcdcActive,
   input  wire logic       ilimPassThrough,
   input  wire logic       ilimBoost,
   input  wire logic       faultEvent,
   input  wire logic       powerGood,
   input  wire logic       thresholdSelectPin,
   // Converter controls
   output logic [1:0]      enableMode,
   output logic            portFunctionSelect,
   output logic            spreadSpectrumOn,
   output logic [1:0]      modeCtrl,
   output logic [4:0]      activeThreshold,
   output logic [5:0]      currentLimit,
   output logic            converterOff,
   output logic            highSpeedOperation,
   output logic            nvWriteProtected
);

   typedef struct packed {
      logic        startAck;
      cicp_phase_t phase;
      logic [3:0]  bitCnt;
      logic [7:0]  shift;
      logic [7:0]  regAddr;
      logic [7:0]  wrData;
      logic [7:0]  txByte;
      logic        ackPend;
      logic        wrReq;
      logic        addrTgl;
      logic        rdTgl;
      logic        hsTgl;
   } cicp_link_t;

   typedef struct packed {
      logic        sdaOe;
      logic        wrTgl;
   } cicp_drive_t;

   typedef struct packed {
      logic [CICP_EV_N-1:0] evA;
      logic [CICP_EV_N-1:0] evB;
      logic [CICP_EV_N-1:0] evSeen;
      logic [7:0]  statA;
      logic [7:0]  statB;
      logic        selA;
      logic        selB;
      logic [7:0]  misc;
      logic [7:0]  lowTh;
      logic [7:0]  highTh;
      logic [7:0]  ilim;
      logic        wen;
      logic        wp;
      logic [7:0]  statLatch;
      logic [7:0]  selAddr;
      logic [7:0]  readWord;
      logic        hs;
      logic        off;
      logic [5:0]  offCnt;
      logic        loadPend;
      logic [7:0]  nvMisc;
      logic [7:0]  nvLowTh;
      logic [7:0]  nvHighTh;
      logic [7:0]  nvIlim;
      logic        nvWp;
      logic [4:0]  thresh;
   } cicp_sys_t;

   localparam cicp_link_t LINK_RST = '{phase: PH_IDLE, default: '0};
   localparam cicp_drive_t DRIVE_RST = '{default: '0};
   localparam cicp_sys_t SYS_RST = '{
      misc:     CICP_MISC_RESET,
      lowTh:    CICP_LOWTH_RESET,
      highTh:   CICP_HIGHTH_RESET,
      ilim:     CICP_ILIM_RESET,
      nvMisc:   CICP_MISC_RESET,
      nvLowTh:  CICP_LOWTH_RESET,
      nvHighTh: CICP_HIGHTH_RESET,
      nvIlim:   CICP_ILIM_RESET,
      loadPend: 1'b1,
      default:  '0
   };

   cicp_link_t  l_q;
   cicp_link_t  l_d;
   cicp_drive_t r_q;
   cicp_drive_t r_d;
   cicp_sys_t   s_q;
   cicp_sys_t   s_d;
   logic        startTgl;
   logic        stopTgl;

   // Readback of one register; status mixes latched and live flags
   function automatic logic [7:0] regRead(input cicp_sys_t s, input logic [7:0] addr);
      logic [7:0] v;
      v = CICP_UNMAPPED_READ;
      unique case (addr)
         CICP_REG_MISC:   v = s.misc;
         CICP_REG_LOWTH:  v = s.lowTh;
         CICP_REG_HIGHTH: v = s.highTh;
         CICP_REG_ILIM:   v = s.ilim;
         CICP_REG_STATUS: v = (s.statLatch & CICP_STAT_STICKY) | (s.statB & ~CICP_STAT_STICKY);
         CICP_REG_NVCTRL: begin
            v[CICP_NV_WEN_BIT]  = s.wen;
            v[CICP_NV_WP_BIT]   = s.wp;
            v[CICP_NV_LOCK_BIT] = s.nvWp;
         end
         default: v = CICP_UNMAPPED_READ;
      endcase
      return v;
   endfunction

   cicp_bus_cond u_cond (
      .nrst     (nrst),
      .scl      (scl),
      .sdaIn    (sdaIn),
      .startTgl (startTgl),
      .stopTgl  (stopTgl)
   );

   // Bit engine on the bus clock: no oversampling, so rates up to CICP_HS_MAX_KBPS are served
   always_comb begin
      logic [7:0] rx;
      rx = {l_q.shift[6:0], sdaIn};
      l_d = l_q;
      if (startTgl != l_q.startAck) begin
         // A fresh start, repeated or not, restarts the frame at address bit 0
         l_d.startAck = startTgl;
         l_d.phase    = PH_DEVADR;
         l_d.bitCnt   = 4'd0;
         l_d.ackPend  = 1'b0;
         rx           = {l_q.shift[6:0], sdaIn};
      end
      unique case (l_d.phase)
         PH_IDLE, PH_DONE: begin
            l_d.bitCnt = 4'd0;
         end
         PH_DEVADR, PH_REGADR, PH_WRDATA: begin
            if (l_d.bitCnt != CICP_BIT_ACK) begin
               l_d.shift  = rx;
               l_d.bitCnt = l_d.bitCnt + 4'd1;
               if (l_d.bitCnt == CICP_BIT_ACK) begin
                  unique case (l_d.phase)
                     PH_DEVADR: begin
                        l_d.ackPend = (rx[7:1] == CICP_SLAVE_ADDR);
                        if (rx[7:3] == CICP_HS_CODE) begin
                           l_d.hsTgl = ~l_q.hsTgl;
                        end
                     end
                     PH_REGADR: begin
                        l_d.regAddr = rx;
                        l_d.ackPend = 1'b1;
                     end
                     default: begin
                        l_d.wrData  = rx;
                        l_d.ackPend = 1'b1;
                     end
                  endcase
               end
            end else begin
               l_d.bitCnt  = 4'd0;
               l_d.ackPend = 1'b0;
               if (!l_q.ackPend) begin
                  l_d.phase = PH_IDLE;
               end else begin
                  unique case (l_d.phase)
                     PH_DEVADR: begin
                        if (l_q.shift[0]) begin
                           l_d.phase  = PH_RDDATA;
                           l_d.txByte = s_q.readWord;
                           l_d.rdTgl  = ~l_q.rdTgl;
                        end else begin
                           l_d.phase = PH_REGADR;
                        end
                     end
                     PH_REGADR: begin
                        l_d.phase   = PH_WRDATA;
                        l_d.addrTgl = ~l_q.addrTgl;
                     end
                     default: begin
                        // Single-register writes; later bytes go unacknowledged
                        l_d.phase = PH_DONE;
                        l_d.wrReq = ~l_q.wrReq;
                     end
                  endcase
               end
            end
         end
         PH_RDDATA: begin
            if (l_d.bitCnt != CICP_BIT_ACK) begin
               l_d.bitCnt = l_d.bitCnt + 4'd1;
            end else begin
               l_d.bitCnt = 4'd0;
               if (sdaIn) begin
                  l_d.phase = PH_IDLE;
               end else begin
                  l_d.txByte = s_q.readWord;
                  l_d.rdTgl  = ~l_q.rdTgl;
               end
            end
         end
      endcase
   end

   always_ff @(posedge scl or negedge nrst) begin
      if (!nrst) begin
         l_q <= LINK_RST;
      end else begin
         l_q <= l_d;
      end
   end

   // Drive changes only after the clock falls, never during its high phase
   always_comb begin
      r_d       = r_q;
      r_d.wrTgl = l_q.wrReq;
      unique case (l_q.phase)
         PH_DEVADR, PH_REGADR, PH_WRDATA: begin
            r_d.sdaOe = (l_q.bitCnt == CICP_BIT_ACK) && l_q.ackPend;
         end
         PH_RDDATA: begin
            r_d.sdaOe = (l_q.bitCnt != CICP_BIT_ACK)
                        && !l_q.txByte[3'(CICP_BIT_LAST - l_q.bitCnt)];
         end
         default: begin
            r_d.sdaOe = 1'b0;
         end
      endcase
   end

   always_ff @(negedge scl or negedge nrst) begin
      if (!nrst) begin
         r_q <= DRIVE_RST;
      end else begin
         r_q <= r_d;
      end
   end

   // System side: the register file, the saved copy and the crossing of bus events
   always_comb begin
      logic [CICP_EV_N-1:0] ev;
      logic [7:0]           clr;
      s_d = s_q;
      ev  = s_q.evB ^ s_q.evSeen;
      clr = (ev[CICP_EV_RD] && s_q.selAddr == CICP_REG_STATUS) ? CICP_STAT_STICKY : 8'h00;
      s_d.evA[CICP_EV_WR]   = r_q.wrTgl;
      s_d.evA[CICP_EV_ADDR] = l_q.addrTgl;
      s_d.evA[CICP_EV_RD]   = l_q.rdTgl;
      s_d.evA[CICP_EV_HS]   = l_q.hsTgl;
      s_d.evA[CICP_EV_STOP] = stopTgl;
      s_d.evB    = s_q.evA;
      s_d.evSeen = s_q.evB;
      s_d.statA  = {thermalTripFlag, hotDie, pfmActive, dcdcActive,
                    ilimPassThrough, ilimBoost, faultEvent, powerGood};
      s_d.statB  = s_q.statA;
      s_d.selA   = thresholdSelectPin;
      s_d.selB   = s_q.selA;

      // A flag raised in the very cycle of its read stays set
      s_d.statLatch = (s_q.statLatch & ~clr) | (s_q.statB & CICP_STAT_STICKY);

      if (ev[CICP_EV_ADDR]) begin
         s_d.selAddr = l_q.regAddr;
      end
      s_d.readWord = regRead(s_q, s_q.selAddr);

      if (s_q.off) begin
         if (s_q.offCnt == 6'd0) begin
            s_d.off = 1'b0;
         end else begin
            s_d.offCnt = s_q.offCnt - 6'd1;
         end
      end

      if (s_q.loadPend) begin
         s_d.loadPend = 1'b0;
         s_d.misc     = s_q.nvMisc;
         s_d.lowTh    = s_q.nvLowTh;
         s_d.highTh   = s_q.nvHighTh;
         s_d.ilim     = s_q.nvIlim;
      end

      if (ev[CICP_EV_WR]) begin
         unique case (l_q.regAddr)
            CICP_REG_MISC: begin
               if (l_q.wrData[CICP_MISC_RST_BIT]) begin
                  s_d.misc   = CICP_MISC_RESET;
                  s_d.lowTh  = CICP_LOWTH_RESET;
                  s_d.highTh = CICP_HIGHTH_RESET;
                  s_d.ilim   = CICP_ILIM_RESET;
                  s_d.wen    = CICP_NVCTRL_RESET[CICP_NV_WEN_BIT];
                  s_d.wp     = CICP_NVCTRL_RESET[CICP_NV_WP_BIT];
                  s_d.off    = 1'b1;
                  s_d.offCnt = CICP_OFF_CYC;
               end else begin
                  s_d.misc = l_q.wrData & CICP_MISC_MASK;
               end
            end
            CICP_REG_LOWTH:  s_d.lowTh  = l_q.wrData & CICP_TH_MASK;
            CICP_REG_HIGHTH: s_d.highTh = l_q.wrData & CICP_TH_MASK;
            CICP_REG_ILIM:   s_d.ilim   = l_q.wrData & CICP_ILIM_MASK;
            CICP_REG_NVCTRL: begin
               s_d.wen = l_q.wrData[CICP_NV_WEN_BIT] & CICP_NVCTRL_MASK[CICP_NV_WEN_BIT];
               s_d.wp  = l_q.wrData[CICP_NV_WP_BIT] & CICP_NVCTRL_MASK[CICP_NV_WP_BIT];
            end
            default: begin
               s_d.misc = s_d.misc;
            end
         endcase
      end

      // Save happens once the frame carrying the enable has stopped
      if (ev[CICP_EV_STOP]) begin
         s_d.hs = 1'b0;
         if (s_q.wen) begin
            if (!s_q.nvWp) begin
               s_d.nvMisc   = s_q.misc;
               s_d.nvLowTh  = s_q.lowTh;
               s_d.nvHighTh = s_q.highTh;
               s_d.nvIlim   = s_q.ilim;
               s_d.nvWp     = s_q.wp;
            end
            s_d.wen = 1'b0;
         end
      end
      if (ev[CICP_EV_HS]) begin
         s_d.hs = 1'b1;
      end

      s_d.thresh = s_q.selB ? s_q.highTh[4:0] : s_q.lowTh[4:0];
   end

   // Reset stands for power-up; registers hold as long as it is not asserted
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= SYS_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign sdaOut             = 1'b0;
   assign sdaOe              = r_q.sdaOe;
   assign enableMode         = s_q.misc[CICP_MISC_EN_LSB +: 2];
   assign portFunctionSelect = s_q.misc[CICP_MISC_PORT_BIT];
   assign spreadSpectrumOn   = s_q.misc[CICP_MISC_SS_BIT];
   assign modeCtrl           = s_q.misc[CICP_MISC_MODE_LSB +: 2];
   assign activeThreshold    = s_q.thresh;
   assign currentLimit       = s_q.ilim[5:0];
   assign converterOff       = s_q.off;
   assign highSpeedOperation = s_q.hs;
   assign nvWriteProtected   = s_q.nvWp;

endmodule // cicp_config_port

// *** rtl/cicp_pkg.sv ***
// Constants of the converter serial configuration port.
// Assumes a 50 MHz system clock and a two-wire bus whose clock comes from the master.
package cicp_pkg;

   // Bus addressing
   localparam logic [6:0] CICP_SLAVE_ADDR = 7'h75;
   localparam logic [4:0] CICP_HS_CODE    = 5'h01;

   // Bus rates the bit engine must keep up with, in kbps
   localparam int CICP_FS_MAX_KBPS = 400;
   localparam int CICP_HS_MAX_KBPS = 3400;

   // Register offsets
   localparam logic [7:0] CICP_REG_MISC   = 8'h01;
   localparam logic [7:0] CICP_REG_LOWTH  = 8'h02;
   localparam logic [7:0] CICP_REG_HIGHTH = 8'h03;
   localparam logic [7:0] CICP_REG_ILIM   = 8'h04;
   localparam logic [7:0] CICP_REG_STATUS = 8'h05;
   localparam logic [7:0] CICP_REG_NVCTRL = 8'hFF;

   // Writable bits; the rest read as zero, except the read-only lock bit of NVCTRL
   localparam logic [7:0] CICP_MISC_MASK   = 8'h6F;
   localparam logic [7:0] CICP_TH_MASK     = 8'h1F;
   localparam logic [7:0] CICP_ILIM_MASK   = 8'h3F;
   localparam logic [7:0] CICP_NVCTRL_MASK = 8'hC0;

   // Field positions
   localparam int CICP_MISC_RST_BIT  = 7;
   localparam int CICP_MISC_EN_LSB   = 5;
   localparam int CICP_MISC_PORT_BIT = 3;
   localparam int CICP_MISC_SS_BIT   = 2;
   localparam int CICP_MISC_MODE_LSB = 0;
   localparam int CICP_NV_WEN_BIT    = 7;
   localparam int CICP_NV_WP_BIT     = 6;
   localparam int CICP_NV_LOCK_BIT   = 5;

   // Status bits that latch until read: thermal trip, both current limits, fault
   localparam logic [7:0] CICP_STAT_STICKY = 8'h8E;

   // Reset and factory values
   localparam logic [7:0] CICP_MISC_RESET    = 8'h01;
   localparam logic [7:0] CICP_LOWTH_RESET   = 8'h06;
   localparam logic [7:0] CICP_HIGHTH_RESET  = 8'h0E;
   localparam logic [7:0] CICP_ILIM_RESET    = 8'h1B;
   localparam logic [7:0] CICP_NVCTRL_RESET  = 8'h00;
   localparam logic [7:0] CICP_UNMAPPED_READ = 8'h00;

   // Bit counter of the serial engine
   localparam logic [3:0] CICP_BIT_LAST = 4'd7;
   localparam logic [3:0] CICP_BIT_ACK  = 4'd8;

   // Indices of the events crossing from the bus into the system clock
   localparam int CICP_EV_WR   = 0;
   localparam int CICP_EV_ADDR = 1;
   localparam int CICP_EV_RD   = 2;
   localparam int CICP_EV_HS   = 3;
   localparam int CICP_EV_STOP = 4;
   localparam int CICP_EV_N    = 5;

   // Timing
   localparam int CICP_SYS_CLK_MHZ = 50;
   localparam int CICP_OFF_NS      = 1000;
   localparam logic [5:0] CICP_OFF_CYC =
      6'((CICP_OFF_NS * CICP_SYS_CLK_MHZ + 999) / 1000);

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_DEVADR,
      PH_REGADR,
      PH_WRDATA,
      PH_DONE,
      PH_RDDATA
   } cicp_phase_t;

endpackage

// *** rtl/cicp_bus_cond.sv ***
// Start and stop detector of the two-wire bus.
// Assumes raw bus pins; each condition flips a toggle: the bit engine compares the start one, the system side the stop one.
`timescale 1ns/1ps
module cicp_bus_cond (
   // Reset
   input  wire logic nrst,
   // Bus pins
   input  wire logic scl,
   input  wire logic sdaIn,
   // Condition toggles
   output logic      startTgl,
   output logic      stopTgl
);

   // Data line edges act as the clock here; only they carry these conditions
   always_ff @(negedge sdaIn or negedge nrst) begin
      if (!nrst) begin
         startTgl <= 1'b0;
      end else if (scl) begin
         startTgl <= ~startTgl;
      end
   end

   always_ff @(posedge sdaIn or negedge nrst) begin
      if (!nrst) begin
         stopTgl <= 1'b0;
      end else if (scl) begin
         stopTgl <= ~stopTgl;
      end
   end

endmodule // cicp_bus_cond

// *** verification/cicp_config_port_asserts.sv ***
// Assertion checker for the serial configuration port.
// Assumes it is bound to the port's top module and sees only its ports.
`timescale 1ns/1ps
module cicp_config_port_asserts (
   // System
   input wire logic       sys_clk,
   input wire logic       nrst,
   // Bus
   input wire logic       scl,
   input wire logic       sdaOe,
   // Converter controls
   input wire logic [1:0] enableMode,
   input wire logic       portFunctionSelect,
   input wire logic       spreadSpectrumOn,
   input wire logic [1:0] modeCtrl,
   input wire logic [5:0] currentLimit,
   input wire logic       converterOff,
   input wire logic       highSpeedOperation,
   input wire logic       nvWriteProtected
);
   localparam int OFF_CYCLES = 51;
   logic [6:0]  offCnt_q;
   logic        fallTgl_q;
   logic        fallSeen_q;
   logic        fallPrev_q;
   logic [3:0]  fallAge_q;
   logic [11:0] cfg;
   assign cfg = {enableMode, portFunctionSelect, spreadSpectrumOn, modeCtrl, currentLimit};
   // Bus clock low phase is shorter than a system cycle, so count from a toggle
   always_ff @(negedge scl or negedge nrst) begin
      if (!nrst)
         fallTgl_q <= 1'b0;
      else
         fallTgl_q <= ~fallTgl_q;
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         offCnt_q   <= 7'h00;
         fallSeen_q <= 1'b0;
         fallPrev_q <= 1'b0;
         fallAge_q  <= 4'hF;
      end else begin
         offCnt_q   <= converterOff ? offCnt_q + 7'h01 : 7'h00;
         fallSeen_q <= fallTgl_q;
         fallPrev_q <= fallSeen_q;
         if (fallSeen_q != fallPrev_q)
            fallAge_q <= 4'h0;
         else if (fallAge_q != 4'hF)
            fallAge_q <= fallAge_q + 4'h1;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence s_sclQuiet;
      scl [*3];
   endsequence
   sequence s_defaults;
      enableMode == 2'h0 && modeCtrl == 2'h1 && !portFunctionSelect && !spreadSpectrumOn
         && currentLimit == 6'h1B;
   endsequence
   property p_offWidth;
      $fell(converterOff) |-> offCnt_q == OFF_CYCLES;
   endproperty
   property p_offBound;
      converterOff |-> offCnt_q < OFF_CYCLES;
   endproperty
   property p_offDefaults;
      $rose(converterOff) |-> ##[0:4] s_defaults;
   endproperty
   property p_hsNoAck;
      $rose(highSpeedOperation) |-> !sdaOe && !$past(sdaOe);
   endproperty
   property p_hsEnd;
      $fell(highSpeedOperation) |-> scl && $past(scl) && $past(scl, 2);
   endproperty
   property p_lockKeep;
      nvWriteProtected |=> nvWriteProtected;
   endproperty
   property p_lockAtStop;
      $rose(nvWriteProtected) |-> scl && $past(scl) && !sdaOe;
   endproperty
   property p_idleRelease;
      s_sclQuiet |-> !sdaOe;
   endproperty
   property p_commit;
      $changed(cfg) |-> fallAge_q <= 4'h6;
   endproperty
   a_offWidth: assert property (p_offWidth)
      else $error("off pulse width wrong");
   a_offBound: assert property (p_offBound)
      else $error("off pulse too long");
   a_offDefaults: assert property (p_offDefaults)
      else $error("defaults not restored");
   a_hsNoAck: assert property (p_hsNoAck)
      else $error("high-speed code acknowledged");
   a_hsEnd: assert property (p_hsEnd)
      else $error("high-speed left without stop");
   a_lockKeep: assert property (p_lockKeep)
      else $error("lock released");
   a_lockAtStop: assert property (p_lockAtStop)
      else $error("lock set outside stop");
   a_idleRelease: assert property (p_idleRelease)
      else $error("data held low on idle bus");
   a_commit: assert property (p_commit)
      else $error("controls changed away from ack edge");
endmodule // cicp_config_port_asserts

bind cicp_config_port cicp_config_port_asserts cicp_config_port_asserts_inst (
   .sys_clk(sys_clk), .nrst(nrst), .scl(scl), .sdaOe(sdaOe), .enableMode(enableMode),
   .portFunctionSelect(portFunctionSelect), .spreadSpectrumOn(spreadSpectrumOn),
   .modeCtrl(modeCtrl), .currentLimit(currentLimit), .converterOff(converterOff),
   .highSpeedOperation(highSpeedOperation), .nvWriteProtected(nvWriteProtected));

// *** verification/cicp_bus_master.sv ***
// Two-wire bus master model, 32 ns bit period.
// Assumes an open-drain data line with pull-up, resolved by the bench.
`timescale 1ns/1ps
module cicp_bus_master (
   // Bus
   output logic      scl,
   output logic      sdaLow,
   input  wire logic sdaLine
);
   localparam time HALF = 16;
   // Clock stands high between frames
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
   task automatic start();
      if (!scl) begin
         sdaLow = 1'b0;
         #HALF scl = 1'b1;
      end
      #HALF sdaLow = 1'b1;
      #HALF scl = 1'b0;
   endtask
   task automatic stop();
      scl = 1'b0;
      #4 sdaLow = 1'b1;
      #12 scl = 1'b1;
      #HALF sdaLow = 1'b0;
      #HALF;
   endtask
   // Data moves only while the clock is low
   task automatic bitXfer(input logic b, output logic rx);
      #4 sdaLow = ~b;
      #12 scl = 1'b1;
      #8 rx = sdaLine;
      #8 scl = 1'b0;
   endtask
   task automatic wrByte(input logic [7:0] d, output logic nack);
      logic rx;
      for (int i = 7; i >= 0; i--) begin
         bitXfer(d[i], rx);
      end
      bitXfer(1'b1, nack);
   endtask
   task automatic rdByte(input logic mAck, output logic [7:0] d);
      logic rx;
      for (int i = 7; i >= 0; i--) begin
         bitXfer(1'b1, d[i]);
      end
      bitXfer(~mAck, rx);
   endtask
endmodule // cicp_bus_master

// *** verification/tb.sv ***
// Self-checking bench for the serial configuration port.
// Assumes the bus master model and the bound checker are compiled with it.
`timescale 1ns/1ps
module tb;
   typedef struct {
      logic [7:0] adr;
      logic [7:0] rstVal;
      logic [7:0] wrVal;
      logic [7:0] rdVal;
   } cicp_row_t;
   localparam int LIMIT = 20000;
   logic       sys_clk = 1'b1;
   logic       nrst = 1'b1;
   logic [7:0] flags = 8'h00;
   logic       thSel = 1'b0;
   logic       scl, sdaLow, sdaOut, sdaOe, nack;
   logic [1:0] enableMode, modeCtrl;
   logic       portFunctionSelect, spreadSpectrumOn;
   logic       converterOff, highSpeedOperation, nvWriteProtected;
   logic [4:0] activeThreshold;
   logic [5:0] currentLimit;
   logic [7:0] rd, rd2;
   int         miscompares = 0;
   int         checks_done = 0;
   int         cycles = 0;
   wire        sdaLine = ~(sdaLow | (sdaOe & ~sdaOut));
   cicp_row_t  rows [8] = '{'{8'h01, 8'h01, 8'h7E, 8'h6E}, '{8'h02, 8'h06, 8'hFF, 8'h1F},
      '{8'h03, 8'h0E, 8'hA5, 8'h05}, '{8'h04, 8'h1B, 8'hFF, 8'h3F},
      '{8'h05, 8'h00, 8'hFF, 8'h00}, '{8'h06, 8'h00, 8'hAA, 8'h00},
      '{8'h00, 8'h00, 8'h55, 8'h00}, '{8'h07, 8'h00, 8'h5A, 8'h00}};
   logic [7:0] badAdr [4] = '{8'hE8, 8'hEC, 8'h00, 8'h6A};

   cicp_config_port cicp_config_port_inst (
      .sys_clk(sys_clk), .nrst(nrst), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .thermalTripFlag(flags[7]), .hotDie(flags[6]), .pfmActive(flags[5]),
      .dcdcActive(flags[4]), .ilimPassThrough(flags[3]), .ilimBoost(flags[2]),
      .faultEvent(flags[1]), .powerGood(flags[0]), .thresholdSelectPin(thSel),
      .enableMode(enableMode), .portFunctionSelect(portFunctionSelect),
      .spreadSpectrumOn(spreadSpectrumOn), .modeCtrl(modeCtrl),
      .activeThreshold(activeThreshold), .currentLimit(currentLimit),
      .converterOff(converterOff), .highSpeedOperation(highSpeedOperation),
      .nvWriteProtected(nvWriteProtected));
   cicp_bus_master cicp_bus_master_inst (.scl(scl), .sdaLow(sdaLow), .sdaLine(sdaLine));

   always #10 sys_clk = ~sys_clk;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic sendAddr(input logic [7:0] a);
      cicp_bus_master_inst.start();
      cicp_bus_master_inst.wrByte(a, nack);
   endtask
   task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
      sendAddr(8'hEA);
      check({7'h00, nack}, 8'h00);
      cicp_bus_master_inst.wrByte(a, nack);
      check({7'h00, nack}, 8'h00);
      cicp_bus_master_inst.wrByte(d, nack);
      check({7'h00, nack}, 8'h00);
      cicp_bus_master_inst.stop();
      repeat (8) @(negedge sys_clk);
   endtask
   // Two bytes per read: the master acknowledge re-sends the register
   task automatic readReg(input logic [7:0] a);
      sendAddr(8'hEA);
      cicp_bus_master_inst.wrByte(a, nack);
      sendAddr(8'hEB);
      check({7'h00, nack}, 8'h00);
      cicp_bus_master_inst.rdByte(1'b1, rd);
      cicp_bus_master_inst.rdByte(1'b0, rd2);
      cicp_bus_master_inst.stop();
      repeat (8) @(negedge sys_clk);
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         $display("mismatch at %0t: run did not finish", $time);
         results();
      end
   end

   initial begin
      // Reset falls after time zero, so every asynchronous reset branch sees the edge
      @(negedge sys_clk);
      nrst = 1'b0;
      repeat (12) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (4) @(negedge sys_clk);
      cicp_bus_master_inst.stop();
      foreach (rows[i]) begin
         readReg(rows[i].adr);
         check(rd, rows[i].rstVal);
         check(rd2, rows[i].rstVal);
         writeReg(rows[i].adr, rows[i].wrVal);
         readReg(rows[i].adr);
         check(rd, rows[i].rdVal);
      end
      check({2'h0, enableMode, portFunctionSelect, spreadSpectrumOn, modeCtrl}, 8'h3E);
      $display("test register table done");
      for (int j = 0; j < 4; j++) begin
         writeReg(8'h01, {1'b0, 2'(j), 3'b000, 2'(j)});
         check({4'h0, enableMode, modeCtrl}, {4'h0, 2'(j), 2'(j)});
      end
      $display("test enable codes done");
      foreach (badAdr[i]) begin
         sendAddr(badAdr[i]);
         check({7'h00, nack}, 8'h01);
         cicp_bus_master_inst.wrByte(8'h02, nack);
         cicp_bus_master_inst.wrByte(8'h00, nack);
         check({7'h00, nack}, 8'h01);
         cicp_bus_master_inst.stop();
      end
      readReg(8'h02);
      check(rd, 8'h1F);
      $display("test foreign addresses done");
      for (int j = 8; j < 16; j++) begin
         sendAddr(8'(j));
         check({7'h00, nack}, 8'h01);
         repeat (4) @(negedge sys_clk);
         check({7'h00, highSpeedOperation}, 8'h01);
         if (j == 15) begin
            writeReg(8'h03, 8'h11);
         end else begin
            cicp_bus_master_inst.stop();
         end
         repeat (6) @(negedge sys_clk);
         check({7'h00, highSpeedOperation}, 8'h00);
      end
      readReg(8'h03);
      check(rd, 8'h11);
      thSel = 1'b1;
      repeat (4) @(negedge sys_clk);
      check({3'h0, activeThreshold}, 8'h11);
      check({2'h0, currentLimit}, 8'h3F);
      thSel = 1'b0;
      $display("test high-speed done");
      flags = 8'h8E;
      repeat (4) @(negedge sys_clk);
      flags = 8'h00;
      repeat (4) @(negedge sys_clk);
      readReg(8'h05);
      check(rd, 8'h8E);
      check(rd2, 8'h00);
      flags = 8'h71;
      repeat (4) @(negedge sys_clk);
      readReg(8'h05);
      check(rd2, 8'h71);
      flags = 8'h00;
      $display("test status done");
      writeReg(8'h01, 8'h80);
      check({7'h00, converterOff}, 8'h01);
      readReg(8'h01);
      check(rd, 8'h01);
      readReg(8'h03);
      check(rd, 8'h0E);
      $display("test config reset done");
      writeReg(8'hFF, 8'h80);
      readReg(8'hFF);
      check(rd, 8'h00);
      writeReg(8'hFF, 8'hC0);
      readReg(8'hFF);
      check(rd, 8'h60);
      writeReg(8'hFF, 8'h80);
      readReg(8'hFF);
      check(rd & 8'h20, 8'h20);
      check({7'h00, nvWriteProtected}, 8'h01);
      $display("test save and lock done");
      nrst = 1'b0;
      repeat (2) @(negedge sys_clk);
      check({6'h00, sdaOe, nvWriteProtected}, 8'h00);
      nrst = 1'b1;
      repeat (4) @(negedge sys_clk);
      readReg(8'h01);
      check(rd, 8'h01);
      $display("test second reset done");
      results();
   end
endmodule // tb
